// file: hdl/ewp_consts.svh
`ifndef EWP_CONSTS_SVH
`define EWP_CONSTS_SVH

// Address byte preambles
`define EWP_PREAMBLE_MEM 4'hA
`define EWP_PREAMBLE_LOCK 4'h6
// Select bits of the reversible lock commands
`define EWP_SEL_SET_REV 3'h1
`define EWP_SEL_CLR_REV 3'h3
// Bits per byte before the acknowledge clock
`define EWP_BITS_PER_BYTE 4'h8
// Address bit that splits lower and upper half
`define EWP_UPPER_HALF_BIT 7
// Page geometry
`define EWP_PAGE_BYTES 16
`define EWP_ARRAY_BYTES 256
// Program cycle time, longest figure
`define EWP_PROG_TIME_NS 5000000
`define EWP_CLK_PERIOD_NS 4
`define EWP_PROG_CYCLES (`EWP_PROG_TIME_NS / `EWP_CLK_PERIOD_NS)
// Reset levels of idle bus lines
`define EWP_LINE_IDLE 1'h1

`endif

// file: hdl/ewp_pkg.sv
package ewp_pkg;

	// Transfer phases
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_WORD = 3'b010,
		ST_DATA = 3'b011,
		ST_IGNORE = 3'b100,
		ST_BUSY = 3'b101
	} ewp_fsm_t;

	// Write commands carried out by a program cycle
	typedef enum logic [2:0] {
		CMD_NONE = 3'b000,
		CMD_MEM = 3'b001,
		CMD_SET_PERM = 3'b010,
		CMD_SET_REV = 3'b011,
		CMD_CLR_REV = 3'b100
	} ewp_cmd_t;

	// Whole controller state
	typedef struct packed {
		ewp_fsm_t state;
		ewp_cmd_t cmd;
		logic scl_q;
		logic sda_q;
		logic [3:0] bit_cnt;
		logic ack_phase;
		logic ack_drive;
		logic [7:0] shreg;
		logic [7:0] addr;
		logic [15:0] mask;
		logic have_data;
		logic wp_latched;
		logic [23:0] prog_cnt;
		logic perm;
		logic rev;
	} ewp_state_t;

endpackage

// file: hdl/ewp_sync.sv
// Three-stage synchroniser; output follows once stages two and three agree
module ewp_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	// Stage chain and filtered output as one state word
	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
		logic [WIDTH-1:0] stage3;
		logic [WIDTH-1:0] filtered;
	} ewp_sync_state_t;

	ewp_sync_state_t st;
	ewp_sync_state_t next_st;

	// Shift chain moves every clock; the filtered bit follows only when stages two and three agree
	always_comb begin
		next_st.stage1 = async_in;
		next_st.stage2 = st.stage1;
		next_st.stage3 = st.stage2;
		next_st.filtered = st.filtered;
		for (int i = 0; i < WIDTH; i++) begin
			if (st.stage2[i] == st.stage3[i]) begin
				next_st.filtered[i] = st.stage3[i];
			end
		end
	end

	// State register
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			st <= {4{RESET_VAL}};
		end else begin
			st <= next_st;
		end
	end

	assign sync_out = st.filtered;

endmodule

// file: hdl/ewp_ctrl.sv
`include "ewp_consts.svh"

// Operation
// - Device byte, word address, data byte, each acked, then a stop.
// - Stop after a write starts program cycle; bus ignored until it ends.
// - Protected writes are acknowledged but leave memory unchanged.
// - Page write takes up to sixteen data bytes, each acked, then stop.
// - Each data byte advances only the low four address bits.
// - Address wraps inside the page; excess bytes overwrite earlier ones.
// - Address byte is acknowledged only after the program cycle ends.
// - Lock bits guard 00H to 7FH; protect pin guards the whole array.
// - Preamble 0110, matching straps and write bit set permanent lock.
// - Once set, permanent lock refuses every 0110 byte and never clears.
// - Byte 01100010, straps 2,1 low, high voltage: set reversible lock.
// - 01100110, strap 2 low, 1 high, high voltage: clear reversible lock.
// - Protect pin high blocks writes to the whole array.
// - Protect pin high blocks programming of both lock bits.
// - With pin low, any lock limits writes to 80H to FFH.
// - Permanent lock query is refused when that lock is set.
// - Reversible lock query is refused when that lock is set.
// - Set permanent lock acked and programmed only while it is clear.
// - Set reversible lock acked and programmed only while it is clear.
// - Clear reversible lock acked and done only without permanent lock.
// - Acknowledge drives data low through the ninth clock.
// - Memory address byte is 1010, three strap bits, then direction bit.
module ewp_ctrl
	import ewp_pkg::*;
#(
	parameter int PROG_CYCLES = `EWP_PROG_CYCLES,
	parameter int PAGE_BYTES = `EWP_PAGE_BYTES,
	parameter int ARRAY_BYTES = `EWP_ARRAY_BYTES
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic strap_pin_0,
	input wire logic strap_pin_1,
	input wire logic strap_pin_2,
	input wire logic high_voltage_level,
	input wire logic write_protect,
	input wire logic [7:0] mem_rd_addr,
	output logic [7:0] mem_rd_data,
	output logic program_busy,
	output logic permanent_lock_bit,
	output logic reversible_lock_bit
);

	localparam logic [23:0] PROG_LAST = 24'(PROG_CYCLES - 1);

	ewp_state_t st;
	ewp_state_t next_st;
	logic [7:0] mem [ARRAY_BYTES];
	logic [7:0] page [PAGE_BYTES];
	logic scl_s;
	logic sda_s;
	logic wp_s;
	logic hv_s;
	logic [2:0] strap_s;
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;
	logic byte_done;
	logic buf_we;
	logic mem_commit;
	logic mem_we;

	// True when the stored target of a memory write may not change
	function automatic logic is_blocked(input logic wp, input logic perm,
			input logic rev, input logic [7:0] a);
		is_blocked = wp | ((perm | rev) & ~a[`EWP_UPPER_HALF_BIT]);
	endfunction

	// Bus lines sampled into the system clock
	ewp_sync #(.WIDTH(2),
		.RESET_VAL({`EWP_LINE_IDLE, `EWP_LINE_IDLE})) u_bus_sync (
		.clk_sys(clk_sys),
		.reset(reset),
		.async_in({scl, sda_in}),
		.sync_out({scl_s, sda_s})
	);

	// Strap pins, protect pin and high voltage flag
	ewp_sync #(.WIDTH(5), .RESET_VAL(5'h00)) u_pin_sync (
		.clk_sys(clk_sys),
		.reset(reset),
		.async_in({write_protect, high_voltage_level, strap_pin_2,
			strap_pin_1, strap_pin_0}),
		.sync_out({wp_s, hv_s, strap_s})
	);

	// Bus conditions from sampled lines
	assign scl_rise = scl_s & ~st.scl_q;
	assign scl_fall = ~scl_s & st.scl_q;
	assign start_ev = scl_s & st.scl_q & st.sda_q & ~sda_s;
	assign stop_ev = scl_s & st.scl_q & ~st.sda_q & sda_s;

	// Next state of the transfer engine
	always_comb begin
		next_st = st;
		byte_done = 1'b0;
		buf_we = 1'b0;
		mem_commit = 1'b0;
		next_st.scl_q = scl_s;
		next_st.sda_q = sda_s;
		if (st.state == ST_BUSY) begin
			// Self-timed cycle; bus is not looked at
			next_st.prog_cnt = st.prog_cnt + 24'h000001;
			if (st.prog_cnt == PROG_LAST) begin
				mem_commit = 1'b1;
				next_st.state = ST_IDLE;
				next_st.mask = 16'h0000;
				if (!st.wp_latched) begin
					case (st.cmd)
						CMD_SET_PERM: next_st.perm = 1'b1;
						CMD_SET_REV: next_st.rev = 1'b1;
						CMD_CLR_REV: begin
							if (!st.perm) begin
								next_st.rev = 1'b0;
							end
						end
						default: ;
					endcase
				end
				next_st.cmd = CMD_NONE;
			end
		end else if (start_ev) begin
			next_st.state = ST_ADDR;
			next_st.bit_cnt = 4'h0;
			next_st.ack_phase = 1'b0;
			next_st.ack_drive = 1'b0;
			next_st.have_data = 1'b0;
			next_st.mask = 16'h0000;
			next_st.cmd = CMD_NONE;
		end else if (stop_ev) begin
			next_st.ack_drive = 1'b0;
			next_st.ack_phase = 1'b0;
			if (st.state == ST_DATA && st.have_data) begin
				next_st.state = ST_BUSY;
				next_st.prog_cnt = 24'h000000;
				next_st.wp_latched = wp_s;
			end else begin
				next_st.state = ST_IDLE;
			end
		end else if (scl_fall && st.ack_phase) begin
			// End of the ninth clock releases the line
			next_st.ack_phase = 1'b0;
			next_st.ack_drive = 1'b0;
			next_st.bit_cnt = 4'h0;
		end else if (st.state == ST_ADDR || st.state == ST_WORD ||
				st.state == ST_DATA) begin
			if (scl_rise && st.bit_cnt != `EWP_BITS_PER_BYTE) begin
				next_st.shreg = {st.shreg[6:0], sda_s};
				next_st.bit_cnt = st.bit_cnt + 4'h1;
			end else if (scl_fall && st.bit_cnt == `EWP_BITS_PER_BYTE) begin
				byte_done = 1'b1;
				next_st.ack_phase = 1'b1;
				next_st.ack_drive = 1'b1;
				case (st.state)
					ST_ADDR: begin
						next_st.ack_drive = 1'b0;
						next_st.state = ST_IGNORE;
						if (st.shreg[7:4] == `EWP_PREAMBLE_MEM &&
								st.shreg[3:1] == strap_s) begin
							next_st.ack_drive = 1'b1;
							next_st.cmd = CMD_MEM;
							next_st.state = st.shreg[0] ? ST_IGNORE : ST_WORD;
						end else if (st.shreg[7:4] == `EWP_PREAMBLE_LOCK &&
								!st.perm) begin
							if (hv_s) begin
								if (st.shreg[3:1] == `EWP_SEL_SET_REV &&
										strap_s[2:1] == 2'h0 && !st.rev) begin
									next_st.ack_drive = 1'b1;
									if (!st.shreg[0]) begin
										next_st.cmd = CMD_SET_REV;
										next_st.state = ST_WORD;
									end
								end else if (st.shreg[3:1] == `EWP_SEL_CLR_REV &&
										strap_s[2:1] == 2'h1 && !st.shreg[0]) begin
									next_st.ack_drive = 1'b1;
									next_st.cmd = CMD_CLR_REV;
									next_st.state = ST_WORD;
								end
							end else if (st.shreg[3:1] == strap_s) begin
								next_st.ack_drive = 1'b1;
								if (!st.shreg[0]) begin
									next_st.cmd = CMD_SET_PERM;
									next_st.state = ST_WORD;
								end
							end
						end
					end
					ST_WORD: begin
						next_st.addr = st.shreg;
						next_st.state = ST_DATA;
					end
					ST_DATA: begin
						next_st.have_data = 1'b1;
						if (st.cmd == CMD_MEM) begin
							buf_we = 1'b1;
							next_st.mask[st.addr[3:0]] = 1'b1;
							next_st.addr = {st.addr[7:4],
								st.addr[3:0] + 4'h1};
						end
					end
					default: ;
				endcase
			end
		end
	end

	// Memory changes only when unprotected at the end of the cycle
	assign mem_we = mem_commit && st.cmd == CMD_MEM &&
		!is_blocked(st.wp_latched, st.perm, st.rev, st.addr);

	// State register
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			st <= '{state: ST_IDLE, cmd: CMD_NONE, scl_q: `EWP_LINE_IDLE,
				sda_q: `EWP_LINE_IDLE, default: '0};
		end else begin
			st <= next_st;
		end
	end

	// Page buffer loads one byte per acknowledged data byte of a memory write
	always_ff @(posedge clk_sys) begin
		if (buf_we) begin
			page[st.addr[3:0]] <= st.shreg;
		end
	end

	// Array update and observation read port
	always_ff @(posedge clk_sys) begin
		if (mem_we) begin
			for (int i = 0; i < PAGE_BYTES; i++) begin
				if (st.mask[i]) begin
					mem[{st.addr[7:4], 4'(i)}] <= page[i];
				end
			end
		end
		mem_rd_data <= mem[mem_rd_addr];
	end

	// Open-drain data line: only ever pulls low
	assign sda_out = 1'b0;
	assign sda_oe = st.ack_drive;
	assign program_busy = (st.state == ST_BUSY);
	assign permanent_lock_bit = st.perm;
	assign reversible_lock_bit = st.rev;

	// Checks
	property p_busy_silent;
		@(posedge clk_sys) disable iff (reset)
		st.state == ST_BUSY |-> !sda_oe;
	endproperty
	a_busy_silent: assert property (p_busy_silent)
		else $error("data line driven during program cycle");

	property p_stop_prog;
		@(posedge clk_sys) disable iff (reset)
		(stop_ev && st.state == ST_DATA && st.have_data) |=>
			(program_busy && st.prog_cnt == 24'h000000);
	endproperty
	a_stop_prog: assert property (p_stop_prog)
		else $error("write stop did not start program cycle");

	property p_busy_hold;
		@(posedge clk_sys) disable iff (reset)
		$rose(program_busy) |-> program_busy [*8];
	endproperty
	a_busy_hold: assert property (p_busy_hold)
		else $error("program cycle ended too early");

	property p_page_wrap;
		@(posedge clk_sys) disable iff (reset)
		buf_we |=> (st.addr[3:0] == $past(st.addr[3:0]) + 4'h1) &&
			(st.addr[7:4] == $past(st.addr[7:4]));
	endproperty
	a_page_wrap: assert property (p_page_wrap)
		else $error("word address stepped outside its page");

	property p_perm_nack;
		@(posedge clk_sys) disable iff (reset)
		(byte_done && st.state == ST_ADDR && st.perm &&
			st.shreg[7:4] == `EWP_PREAMBLE_LOCK) |=> !sda_oe;
	endproperty
	a_perm_nack: assert property (p_perm_nack)
		else $error("lock preamble acknowledged after permanent lock");

	property p_mem_ack;
		@(posedge clk_sys) disable iff (reset)
		(byte_done && st.state == ST_ADDR && st.shreg[3:1] == strap_s &&
			st.shreg[7:4] == `EWP_PREAMBLE_MEM) |=> sda_oe && !sda_out;
	endproperty
	a_mem_ack: assert property (p_mem_ack)
		else $error("matching memory address byte not acknowledged");

	property p_data_ack;
		@(posedge clk_sys) disable iff (reset)
		(byte_done && st.state == ST_DATA) |=> sda_oe until scl_fall;
	endproperty
	a_data_ack: assert property (p_data_ack)
		else $error("data byte acknowledge dropped early");

	property p_protect_mem;
		@(posedge clk_sys) disable iff (reset)
		mem_we |-> !st.wp_latched &&
			(st.addr[`EWP_UPPER_HALF_BIT] || !(st.perm || st.rev));
	endproperty
	a_protect_mem: assert property (p_protect_mem)
		else $error("protected page was written");

	property p_wp_locks;
		@(posedge clk_sys) disable iff (reset)
		(st.state == ST_BUSY && st.wp_latched) |=>
			$stable(st.perm) && $stable(st.rev);
	endproperty
	a_wp_locks: assert property (p_wp_locks)
		else $error("lock bit changed with protect pin high");

	property p_perm_sticky;
		@(posedge clk_sys) disable iff (reset)
		st.perm |=> st.perm;
	endproperty
	a_perm_sticky: assert property (p_perm_sticky)
		else $error("permanent lock cleared");

	property p_rev_clear;
		@(posedge clk_sys) disable iff (reset)
		$fell(st.rev) |-> !st.perm && !$past(st.wp_latched);
	endproperty
	a_rev_clear: assert property (p_rev_clear)
		else $error("reversible lock cleared while barred");

endmodule

// file: verification/ewp_bus_ctl.sv
// Two-wire bus controller driving the serial clock and data
module ewp_bus_ctl (
	input wire logic clk_sys,
	input wire logic sda_wire,
	output logic scl,
	output logic sda_drv
);
	timeunit 1ns;
	timeprecision 1ps;
	// Quarter of the 160 ns serial period, in system clocks
	localparam int QTR = 10;
	// Clock stands high and data is released between frames
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic qw(input int n);
		repeat (n * QTR) @(negedge clk_sys);
	endtask
	// Data falls while clock high
	task automatic start_c;
		sda_drv = 1'b1;
		qw(1);
		scl = 1'b1;
		qw(1);
		sda_drv = 1'b0;
		qw(1);
		scl = 1'b0;
	endtask
	// Most significant bit first; data moves only with clock low
	task automatic send_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			qw(1);
			sda_drv = b[i];
			qw(1);
			scl = 1'b1;
			qw(2);
			scl = 1'b0;
		end
		// Release for the ninth clock and look for a low
		qw(1);
		sda_drv = 1'b1;
		qw(1);
		scl = 1'b1;
		qw(1);
		ack = (sda_wire === 1'b0);
		qw(1);
		scl = 1'b0;
	endtask
	// Data rises while clock high; ends every frame
	task automatic stop_c;
		qw(1);
		sda_drv = 1'b0;
		qw(1);
		scl = 1'b1;
		qw(1);
		sda_drv = 1'b1;
		qw(1);
	endtask
endmodule

// file: verification/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PROG = 600;
	logic clk_sys, reset, scl, sda_drv, sda_out, sda_oe, sda_wire;
	logic s0, s1, s2, hv, wp, busy, perm, rev;
	logic [7:0] rd_addr, rd_data;
	int mismatches = 0;
	int n_compared = 0;
	int cycles = 0;
	// Open-drain wire with pull-up
	assign sda_wire = sda_drv & ~(sda_oe & ~sda_out);
	ewp_ctrl #(.PROG_CYCLES(PROG)) i_dut (.clk_sys(clk_sys),
		.reset(reset), .scl(scl), .sda_in(sda_wire), .sda_out(sda_out),
		.sda_oe(sda_oe), .strap_pin_0(s0), .strap_pin_1(s1),
		.strap_pin_2(s2), .high_voltage_level(hv), .write_protect(wp),
		.mem_rd_addr(rd_addr), .mem_rd_data(rd_data),
		.program_busy(busy), .permanent_lock_bit(perm),
		.reversible_lock_bit(rev));
	ewp_bus_ctl i_ctl (.clk_sys(clk_sys), .sda_wire(sda_wire),
		.scl(scl), .sda_drv(sda_drv));
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	task automatic wrap_up;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Hang guard
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			mismatches++;
			wrap_up();
		end
	end
	task automatic chk(input string w, input logic [7:0] e, logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", w, e, g);
		end
	endtask
	// One framed transfer; returns how many bytes were acknowledged
	task automatic frame(input logic [7:0] q[$], output logic [7:0] n);
		logic a;
		n = 8'h00;
		i_ctl.start_c();
		foreach (q[i]) begin
			i_ctl.send_byte(q[i], a);
			n = n + {7'h00, a};
		end
		i_ctl.stop_c();
	endtask
	// Full program cycle is waited out, bounded
	task automatic settle;
		int k;
		k = 0;
		while (busy !== 1'b0 && k < 2 * PROG) begin
			@(negedge clk_sys);
			k++;
		end
		chk("busy end", 8'h00, {7'h00, busy});
	endtask
	task automatic chkmem(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk_sys);
		rd_addr = a;
		repeat (2) @(negedge clk_sys);
		chk("memory", e, rd_data);
	endtask
	function automatic logic [7:0] dev(input logic rd);
		return {4'hA, s2, s1, s0, rd};
	endfunction
	task automatic t_byte;
		logic [7:0] n;
		frame('{dev(1'b0), 8'h05, 8'h5A}, n);
		chk("acks", 8'h03, n);
		chk("busy", 8'h01, {7'h00, busy});
		frame('{dev(1'b0)}, n);
		chk("poll busy", 8'h00, n);
		settle();
		frame('{dev(1'b1)}, n);
		chk("poll done", 8'h01, n);
		chkmem(8'h05, 8'h5A);
		frame('{{4'hA, ~s2, s1, s0, 1'b0}, 8'h05, 8'h77}, n);
		chk("strap miss", 8'h00, n);
		$display("test byte write done");
	endtask
	task automatic t_page;
		logic [7:0] n;
		logic [7:0] q[$];
		logic [7:0] e[16];
		q = '{dev(1'b0), 8'h2E};
		for (int i = 0; i < 18; i++) begin
			q.push_back(8'hC0 + 8'(i));
			e[(14 + i) % 16] = 8'hC0 + 8'(i);
		end
		frame(q, n);
		chk("page acks", 8'h14, n);
		settle();
		for (int k = 0; k < 16; k++)
			chkmem(8'h20 + 8'(k), e[k]);
		$display("test page write done");
	endtask
	task automatic t_rev;
		logic [7:0] n;
		hv = 1'b1;
		s0 = 1'b1;
		frame('{8'h62, 8'h00, 8'h00}, n);
		chk("set rev", 8'h03, n);
		settle();
		chk("rev", 8'h01, {7'h00, rev});
		frame('{8'h63}, n);
		chk("query rev", 8'h00, n);
		frame('{8'h62, 8'h00, 8'h00}, n);
		chk("set rev again", 8'h00, n);
		hv = 1'b0;
		s0 = 1'b0;
		frame('{dev(1'b0), 8'h05, 8'hA5}, n);
		chk("low acks", 8'h03, n);
		settle();
		frame('{dev(1'b0), 8'h85, 8'h3C}, n);
		settle();
		chkmem(8'h05, 8'h5A);
		chkmem(8'h85, 8'h3C);
		hv = 1'b1;
		s0 = 1'b1;
		s1 = 1'b1;
		frame('{8'h66, 8'h00, 8'h00}, n);
		chk("clear rev", 8'h03, n);
		settle();
		chk("rev", 8'h00, {7'h00, rev});
		s1 = 1'b0;
		frame('{8'h63}, n);
		chk("query rev", 8'h01, n);
		$display("test reversible lock done");
	endtask
	task automatic t_hwp;
		logic [7:0] n;
		wp = 1'b1;
		hv = 1'b0;
		s0 = 1'b0;
		frame('{dev(1'b0), 8'h85, 8'hEE}, n);
		chk("wp acks", 8'h03, n);
		settle();
		chkmem(8'h85, 8'h3C);
		hv = 1'b1;
		s0 = 1'b1;
		frame('{8'h62, 8'h00, 8'h00}, n);
		chk("wp set rev", 8'h03, n);
		settle();
		chk("rev", 8'h00, {7'h00, rev});
		wp = 1'b0;
		$display("test protect pin done");
	endtask
	task automatic t_perm;
		logic [7:0] n;
		hv = 1'b0;
		s0 = 1'b0;
		frame('{8'h61}, n);
		chk("query perm", 8'h01, n);
		frame('{8'h60, 8'h00, 8'h00}, n);
		chk("set perm", 8'h03, n);
		settle();
		chk("perm", 8'h01, {7'h00, perm});
		frame('{8'h60, 8'h00, 8'h00}, n);
		chk("set perm again", 8'h00, n);
		frame('{8'h61}, n);
		chk("query perm", 8'h00, n);
		frame('{dev(1'b0), 8'h05, 8'h11}, n);
		chk("perm acks", 8'h03, n);
		settle();
		chkmem(8'h05, 8'h5A);
		frame('{dev(1'b0), 8'h86, 8'h4B}, n);
		settle();
		chkmem(8'h86, 8'h4B);
		hv = 1'b1;
		s0 = 1'b1;
		s1 = 1'b1;
		frame('{8'h66, 8'h00, 8'h00}, n);
		chk("clear rev", 8'h00, n);
		chk("perm", 8'h01, {7'h00, perm});
		$display("test permanent lock done");
	endtask
	// Reset, then the scenarios in order
	initial begin
		reset = 1'b1;
		{s0, s1, s2, hv, wp} = 5'h00;
		rd_addr = 8'h00;
		repeat (4) @(negedge clk_sys);
		reset = 1'b0;
		repeat (10) @(negedge clk_sys);
		chk("locks", 8'h00, {6'h00, perm, rev});
		t_byte();
		t_page();
		t_rev();
		t_hwp();
		t_perm();
		wrap_up();
	end
endmodule
